// *** hdl/nspc_pkg.sv ***
// Constants, types and address decode for the self-programming controller.
// Assumes a 20-bit byte address space and an 8-bit register port.
package nspc_pkg;
  localparam logic [19:0] REG_KEY = 20'h0_3D80;
  localparam logic [19:0] REG_ADDR_L = 20'h0_3D82;
  localparam logic [19:0] REG_ADDR_M = 20'h0_3D83;
  localparam logic [19:0] REG_ADDR_H = 20'h0_3D84;
  localparam logic [19:0] REG_LEN = 20'h0_3D85;
  localparam logic [19:0] REG_PTR_L = 20'h0_3D86;
  localparam logic [19:0] REG_PTR_M = 20'h0_3D87;
  localparam logic [19:0] REG_STAT = 20'h0_3D88;
  localparam logic [19:0] REG_RES = 20'h0_3D89;
  localparam logic [7:0] KEY_VAL = 8'h4B;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [19:0] CODE0_LO = 20'h0_4000;
  localparam logic [19:0] CODE0_HI = 20'h0_40FF;
  localparam logic [19:0] CODE1_LO = 20'h0_4900;
  localparam logic [19:0] CODE1_HI = 20'h1_3FFF;
  localparam logic [19:0] DATA_LO = 20'h0_4100;
  localparam logic [19:0] DATA_HI = 20'h0_48FF;
  localparam logic [19:0] RSV_LO = 20'h6_F000;
  localparam logic [19:0] RSV_HI = 20'h6_FBFF;
  localparam logic [19:0] E_WCODE = 20'h6_F205;
  localparam logic [19:0] E_WDATA = 20'h6_F20A;
  localparam logic [19:0] E_PROT = 20'h6_F210;
  localparam logic [19:0] E_KSET = 20'h6_F215;
  localparam logic [19:0] E_KCHK = 20'h6_F21A;
  localparam logic [19:0] E_BYTE = 20'h6_F220;
  localparam logic [19:0] E_BSUSP = 20'h6_F225;
  localparam logic [19:0] E_WSUSP = 20'h6_F22A;
  localparam logic [6:0] MAX_BYTES = 7'h40;
  localparam logic [7:0] MAX_LEN = 8'h3F;
  localparam logic [1:0] CODE_CYC = 2'h1;
  localparam logic [1:0] DATA_CYC = 2'h2;
  localparam int CLK_NS = 8;
  localparam int TMO_US = 100;
  localparam int TMO_CYC = TMO_US * 1000 / CLK_NS;
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_PARAM = 8'h01;
  localparam logic [7:0] RES_PROT = 8'h02;
  localparam logic [7:0] RES_SEC = 8'h03;
  localparam logic [7:0] RES_KEY = 8'h04;
  localparam logic [7:0] RES_TMO = 8'h05;
  localparam logic [7:0] RES_DBL = 8'h06;
  localparam logic [7:0] RES_ENTRY = 8'h07;
  localparam logic [7:0] RES_FULL = 8'h08;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RD = 3'b001,
    ST_WAIT = 3'b010,
    ST_PROG = 3'b011,
    ST_DONE = 3'b100
  } nspc_state_t;

  function automatic logic in_code(input logic [19:0] a);
    in_code = (a >= CODE0_LO && a <= CODE0_HI) || (a >= CODE1_LO && a <= CODE1_HI);
  endfunction

  function automatic logic in_data(input logic [19:0] a);
    in_data = a >= DATA_LO && a <= DATA_HI;
  endfunction

  function automatic logic in_rsv(input logic [19:0] a);
    in_rsv = a >= RSV_LO && a <= RSV_HI;
  endfunction
endpackage

// *** hdl/nspc_prot_tbl.sv ***
// Table of up to three write-protected ranges with an overlap check.
// Assumes the owner adds ranges by a one-cycle pulse; nothing ever removes one.
`timescale 1ns/100ps
module nspc_prot_tbl (
  input wire logic clk,
  input wire logic rst,
  input wire logic add_en,
  input wire logic [19:0] add_start,
  input wire logic [15:0] add_size,
  input wire logic [19:0] chk_lo,
  input wire logic [20:0] chk_hi,
  output logic hit,
  output logic full
);
  import nspc_pkg::*;
  logic [20:0] start_ff [3];
  logic [20:0] end_ff [3];
  logic [2:0] used_ff;

  // First free slot takes the range; no clear path exists on purpose
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      used_ff <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        start_ff[i] <= 21'h00_0000;
        end_ff[i] <= 21'h00_0000;
      end
    end else if (add_en) begin
      if (!used_ff[0]) begin
        used_ff[0] <= 1'b1;
        start_ff[0] <= {1'b0, add_start};
        end_ff[0] <= {1'b0, add_start} + {5'h00, add_size} - 21'h00_0001;
      end else if (!used_ff[1]) begin
        used_ff[1] <= 1'b1;
        start_ff[1] <= {1'b0, add_start};
        end_ff[1] <= {1'b0, add_start} + {5'h00, add_size} - 21'h00_0001;
      end else if (!used_ff[2]) begin
        used_ff[2] <= 1'b1;
        start_ff[2] <= {1'b0, add_start};
        end_ff[2] <= {1'b0, add_start} + {5'h00, add_size} - 21'h00_0001;
      end
    end
  end

  always_comb begin
    hit = 1'b0;
    for (int i = 0; i < 3; i++) begin
      if (used_ff[i] && {1'b0, chk_lo} <= end_ff[i] && start_ff[i] <= chk_hi) begin
        hit = 1'b1;
      end
    end
  end

  assign full = &used_ff;
endmodule

// *** hdl/nspc_ctrl.sv ***
// Self-programming controller: register file, read timing, library call gating,
// byte programming engine, protection and key security.
// Assumes CPU, RAM and memory macro share clk; RAM answers a read next cycle.
//
// Contract
// [RULE1] Code area reads in one cycle, writable
// [RULE2] Data area reads in two cycles, writable
// [RULE3] Library area reads one cycle, never written
// [RULE4] Byte units, at most sixty-four per operation
// [RULE5] Up to three protected ranges, start plus size
// [RULE6] Protected range refuses writes, never released
// [RULE7] Security blocks all reads and programming; 128-bit key (library area reads are still answered)
// [RULE8] Stored key cannot be replaced later
// [RULE9] Programming enabled only while key register holds 4B
// [RULE10] Library call without 4B raises NMI
// [RULE11] Interrupt suspends library, resumes afterwards
// [RULE12] Nested library call flags double activation
// [RULE13] Software loads target address registers
// [RULE14] Software loads byte count minus one
// [RULE15] Software loads RAM source pointer
// [RULE16] Code write entry programs two to sixty-four bytes
// [RULE17] Data multi-byte write entry
// [RULE18] Data single-byte write entry
// [RULE19] Protection set entry
// [RULE20] Key set and key check entries
// [RULE21] Timed byte and word data writes
// [RULE22] Result code left in data register zero
// [RULE23] Parameters latched at call time
// [RULE24] Refused write leaves memory, returns nonzero code
`timescale 1ns/100ps
module nspc_ctrl #(
  parameter int TMO_CYCLES = nspc_pkg::TMO_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [19:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  input wire logic rd_req,
  input wire logic [19:0] rd_addr,
  output logic rd_ack,
  output logic rd_deny,
  input wire logic lib_call,
  input wire logic [19:0] lib_entry,
  input wire logic [127:0] lib_key,
  input wire logic irq_active,
  output logic nmi,
  output logic dbl_err,
  output logic lib_done,
  output logic [7:0] data_register_zero,
  output logic busy,
  output logic ram_re,
  output logic [15:0] ram_addr,
  input wire logic [7:0] ram_rdata,
  output logic nvm_we,
  output logic [19:0] nvm_addr,
  output logic [7:0] nvm_wdata,
  input wire logic nvm_done
);
  import nspc_pkg::*;

  logic [7:0] rewrite_enable_key_ff, addr_l_ff, addr_m_ff, addr_h_ff, len_ff, ptr_l_ff, ptr_m_ff;
  logic [127:0] key_ff;
  logic key_set_ff, secure_ff, lift_ff, dbl_sticky_ff;
  logic [1:0] rd_cnt_ff;
  nspc_state_t state_ff;
  logic [6:0] cnt_ff;
  logic timed_ff;
  logic [13:0] tmo_ff;
  logic [7:0] res_ff;
  logic [19:0] tgt;
  logic [6:0] len;
  logic [20:0] last;
  logic key_ok, blocked, prot_hit, prot_full;
  logic call_start, call_timed, call_prot, call_kset, call_klift, wr_kind, region_ok;
  logic [6:0] call_n;
  logic [7:0] call_res;

  assign tgt = {addr_h_ff[3:0], addr_m_ff, addr_l_ff};
  assign key_ok = rewrite_enable_key_ff == KEY_VAL;
  assign blocked = secure_ff && !lift_ff;

  // Register writes; the status write only clears the sticky error
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rewrite_enable_key_ff <= REG_RST;
      addr_l_ff <= REG_RST;
      addr_m_ff <= REG_RST;
      addr_h_ff <= REG_RST;
      len_ff <= REG_RST;
      ptr_l_ff <= REG_RST;
      ptr_m_ff <= REG_RST;
    end else if (reg_we) begin
      case (reg_addr)
        REG_KEY: rewrite_enable_key_ff <= reg_wdata;
        REG_ADDR_L: addr_l_ff <= reg_wdata;
        REG_ADDR_M: addr_m_ff <= reg_wdata;
        REG_ADDR_H: addr_h_ff <= reg_wdata;
        REG_LEN: len_ff <= reg_wdata;
        REG_PTR_L: ptr_l_ff <= reg_wdata;
        REG_PTR_M: ptr_m_ff <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Unmapped addresses read as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_re) begin
      case (reg_addr)
        REG_KEY: reg_rdata <= rewrite_enable_key_ff;
        REG_ADDR_L: reg_rdata <= addr_l_ff;
        REG_ADDR_M: reg_rdata <= addr_m_ff;
        REG_ADDR_H: reg_rdata <= addr_h_ff;
        REG_LEN: reg_rdata <= len_ff;
        REG_PTR_L: reg_rdata <= ptr_l_ff;
        REG_PTR_M: reg_rdata <= ptr_m_ff;
        REG_STAT: reg_rdata <= {busy, blocked, key_set_ff, dbl_sticky_ff, prot_full, 3'h0};
        REG_RES: reg_rdata <= data_register_zero;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Read access timing; requests during a pending read are dropped
  // Count holds the cycles still owed, so the ack lands in the last one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_cnt_ff <= 2'h0;
      rd_ack <= 1'b0;
      rd_deny <= 1'b0;
    end else begin
      rd_ack <= 1'b0;
      rd_deny <= 1'b0;
      if (rd_cnt_ff != 2'h0) begin
        rd_cnt_ff <= rd_cnt_ff - 2'h1;
        rd_ack <= rd_cnt_ff == 2'h1;
      end else if (rd_req) begin
        if (in_rsv(rd_addr)) begin
          rd_cnt_ff <= CODE_CYC - 2'h1; // RULE3
          rd_ack <= CODE_CYC == 2'h1;
        end else if (blocked) begin
          rd_deny <= 1'b1; // RULE7
        end else if (in_code(rd_addr)) begin
          rd_cnt_ff <= CODE_CYC - 2'h1; // RULE1
          rd_ack <= CODE_CYC == 2'h1;
        end else if (in_data(rd_addr)) begin
          rd_cnt_ff <= DATA_CYC - 2'h1; // RULE2
          rd_ack <= DATA_CYC == 2'h1;
        end else begin
          rd_deny <= 1'b1;
        end
      end
    end
  end

  // Call decode from the live registers, so parameters are those at call time
  always_comb begin
    len = {1'b0, len_ff[5:0]} + 7'h01;
    call_n = len;
    call_timed = 1'b0;
    wr_kind = 1'b0;
    region_ok = 1'b0;
    call_prot = 1'b0;
    call_kset = 1'b0;
    call_klift = 1'b0;
    call_res = RES_OK;
    case (lib_entry)
      E_WCODE: begin
        wr_kind = 1'b1;
        region_ok = len >= 7'h02 && len_ff <= MAX_LEN; // RULE16 RULE4
      end
      E_WDATA: begin
        wr_kind = 1'b1;
        region_ok = len_ff <= MAX_LEN; // RULE17
      end
      E_BYTE: begin
        wr_kind = 1'b1;
        call_n = 7'h01; // RULE18
        region_ok = 1'b1;
      end
      E_BSUSP, E_WSUSP: begin
        wr_kind = 1'b1;
        call_timed = 1'b1; // RULE21
        call_n = (lib_entry == E_WSUSP) ? 7'h02 : 7'h01;
        region_ok = 1'b1;
      end
      default: ;
    endcase
    last = {1'b0, tgt} + {14'h0000, call_n} - 21'h00_0001;
    if (lib_entry == E_WCODE) begin
      region_ok = region_ok && !last[20] && in_code(tgt) && in_code(last[19:0])
        && !(tgt < DATA_LO && last[19:0] > DATA_HI);
    end else if (wr_kind) begin
      region_ok = region_ok && !last[20] && in_data(tgt) && in_data(last[19:0]);
    end
    if (wr_kind) begin
      if (blocked) begin
        call_res = RES_SEC; // RULE7
      end else if (!region_ok) begin
        call_res = RES_PARAM; // RULE24 RULE3
      end else if (prot_hit) begin
        call_res = RES_PROT; // RULE6 RULE24
      end
    end else if (lib_entry == E_PROT) begin
      if (blocked) begin
        call_res = RES_SEC;
      end else if (prot_full) begin
        call_res = RES_FULL;
      end else if ({ptr_m_ff, ptr_l_ff} == 16'h0000) begin
        call_res = RES_PARAM;
      end else begin
        call_prot = 1'b1; // RULE19 RULE5
      end
    end else if (lib_entry == E_KSET) begin
      if (key_set_ff && lib_key != key_ff) begin
        call_res = RES_KEY; // RULE8
      end else begin
        call_kset = 1'b1; // RULE20
      end
    end else if (lib_entry == E_KCHK) begin
      if (key_set_ff && lib_key == key_ff) begin
        call_klift = 1'b1; // RULE20
      end else begin
        call_res = RES_KEY;
      end
    end else begin
      call_res = RES_ENTRY;
    end
    call_start = wr_kind && call_res == RES_OK;
  end

  nspc_prot_tbl u_prot (
    .clk(clk),
    .rst(rst),
    .add_en(lib_call && key_ok && !busy && call_prot),
    .add_start(tgt),
    .add_size({ptr_m_ff, ptr_l_ff}),
    .chk_lo(tgt),
    .chk_hi(last),
    .hit(prot_hit),
    .full(prot_full)
  );

  // Security state; once set, the key is only rewritten with its own value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_ff <= 128'h0;
      key_set_ff <= 1'b0;
      secure_ff <= 1'b0;
      lift_ff <= 1'b0;
    end else if (lib_call && key_ok && !busy) begin
      if (call_kset) begin
        key_ff <= lib_key; // RULE8
        key_set_ff <= 1'b1;
        secure_ff <= 1'b1;
        lift_ff <= 1'b0;
      end
      if (call_klift) begin
        lift_ff <= 1'b1; // Lasts until reset or a new key set
      end
    end
  end

  // Call gating: missing key gives NMI, nested call gives double activation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      nmi <= 1'b0;
      dbl_err <= 1'b0;
      dbl_sticky_ff <= 1'b0;
    end else begin
      nmi <= lib_call && !key_ok; // RULE10
      dbl_err <= lib_call && key_ok && busy; // RULE12
      if (lib_call && key_ok && busy) begin
        dbl_sticky_ff <= 1'b1; // Set wins over the clear below
      end else if (reg_we && reg_addr == REG_STAT && reg_wdata[4]) begin
        dbl_sticky_ff <= 1'b0;
      end
    end
  end

  // Programming engine; while an interrupt is serviced it finishes the current byte, then holds in ST_RD
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      cnt_ff <= 7'h00;
      timed_ff <= 1'b0;
      tmo_ff <= 14'h0000;
      res_ff <= RES_OK;
      busy <= 1'b0;
      ram_re <= 1'b0;
      ram_addr <= 16'h0000;
      nvm_we <= 1'b0;
      nvm_addr <= 20'h0_0000;
      nvm_wdata <= 8'h00;
      lib_done <= 1'b0;
      data_register_zero <= 8'h00;
    end else begin
      ram_re <= 1'b0;
      nvm_we <= 1'b0;
      lib_done <= 1'b0;
      if (timed_ff && !irq_active && state_ff != ST_IDLE && state_ff != ST_DONE) begin
        tmo_ff <= tmo_ff + 14'h0001;
      end
      case (state_ff)
        ST_IDLE: begin
          if (lib_call && key_ok) begin
            busy <= 1'b1;
            res_ff <= call_res;
            tmo_ff <= 14'h0000;
            if (call_start) begin
              cnt_ff <= call_n; // RULE23
              timed_ff <= call_timed;
              nvm_addr <= tgt; // RULE13
              ram_addr <= {ptr_m_ff, ptr_l_ff}; // RULE15
              state_ff <= ST_RD;
            end else begin
              state_ff <= ST_DONE;
            end
          end
        end
        ST_RD: begin
          if (timed_ff && tmo_ff >= 14'(TMO_CYCLES)) begin
            res_ff <= RES_TMO; // RULE21
            state_ff <= ST_DONE;
          end else if (!irq_active && key_ok) begin
            ram_re <= 1'b1; // RULE11 RULE9
            state_ff <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          // RAM data stands only in the cycle after ram_re
          if (!ram_re) begin
            nvm_wdata <= ram_rdata;
            nvm_we <= 1'b1; // RULE4
            state_ff <= ST_PROG;
          end
        end
        ST_PROG: begin
          if (timed_ff && tmo_ff >= 14'(TMO_CYCLES)) begin
            res_ff <= RES_TMO;
            state_ff <= ST_DONE;
          end else if (nvm_done) begin
            cnt_ff <= cnt_ff - 7'h01;
            if (cnt_ff == 7'h01) begin
              state_ff <= ST_DONE;
            end else begin
              nvm_addr <= nvm_addr + 20'h0_0001;
              ram_addr <= ram_addr + 16'h0001;
              state_ff <= ST_RD;
            end
          end
        end
        ST_DONE: begin
          data_register_zero <= res_ff; // RULE22
          lib_done <= 1'b1;
          busy <= 1'b0;
          timed_ff <= 1'b0;
          state_ff <= ST_IDLE;
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Checks beside the logic
  chk_code_read_one: assert property (@(posedge clk) disable iff (rst) // RULE1
    rd_req && rd_cnt_ff == 2'h0 && !blocked && in_code(rd_addr) |=> rd_ack)
    else $error("code read not acknowledged in one cycle");
  chk_data_read_two: assert property (@(posedge clk) disable iff (rst) // RULE2
    rd_req && rd_cnt_ff == 2'h0 && !blocked && in_data(rd_addr) |=> !rd_ack ##1 rd_ack)
    else $error("data read not acknowledged in two cycles");
  chk_rsv_no_write: assert property (@(posedge clk) disable iff (rst) // RULE3
    nvm_we |-> !in_rsv(nvm_addr) && (in_code(nvm_addr) || in_data(nvm_addr)))
    else $error("write outside writable areas");
  chk_byte_count_max: assert property (@(posedge clk) disable iff (rst) // RULE4
    state_ff != ST_IDLE |-> cnt_ff <= MAX_BYTES)
    else $error("byte count above limit");
  chk_prot_refused: assert property (@(posedge clk) disable iff (rst) // RULE6
    lib_call && key_ok && !busy && call_res == RES_PROT |-> ##2 lib_done && data_register_zero == RES_PROT
      ##0 $past(!nvm_we) && !nvm_we)
    else $error("protected write not refused");
  chk_secure_read: assert property (@(posedge clk) disable iff (rst) // RULE7
    rd_req && rd_cnt_ff == 2'h0 && blocked && !in_rsv(rd_addr) |=> rd_deny && !rd_ack)
    else $error("secured read not denied");
  chk_key_fixed: assert property (@(posedge clk) disable iff (rst) // RULE8
    key_set_ff |=> key_set_ff && $stable(key_ff))
    else $error("stored key changed");
  chk_enable_gate: assert property (@(posedge clk) disable iff (rst) // RULE9
    nvm_we |-> $past(rewrite_enable_key_ff, 3) == KEY_VAL)
    else $error("programming without enable value");
  chk_nmi_no_key: assert property (@(posedge clk) disable iff (rst) // RULE10
    lib_call && !key_ok |=> nmi && !dbl_err ##1 !lib_done)
    else $error("missing NMI on gated call");
  chk_suspend_hold: assert property (@(posedge clk) disable iff (rst) // RULE11
    irq_active && state_ff == ST_RD |=> !ram_re)
    else $error("engine ran during interrupt");
  chk_double_call: assert property (@(posedge clk) disable iff (rst) // RULE12
    lib_call && key_ok && busy |=> dbl_err && dbl_sticky_ff)
    else $error("double activation not flagged");
  chk_result_reg: assert property (@(posedge clk) disable iff (rst) // RULE22
    state_ff == ST_DONE |=> lib_done && data_register_zero == $past(res_ff))
    else $error("result code not returned");

  cov_code_write: cover property (@(posedge clk) disable iff (rst)
    lib_call && key_ok && call_start && lib_entry == E_WCODE ##[1:600] lib_done && data_register_zero == RES_OK);
  cov_nmi: cover property (@(posedge clk) disable iff (rst) nmi);
  cov_double: cover property (@(posedge clk) disable iff (rst) irq_active && busy ##1 dbl_err);
  cov_timeout: cover property (@(posedge clk) disable iff (rst) lib_done && data_register_zero == RES_TMO);
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the self-programming controller.
// Assumes the bench plays CPU, RAM and memory macro on the one clock.
`timescale 1ns/100ps
module testbench;
  import nspc_pkg::*;
  `define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %0t got %h exp %h", $time, a, e); end end
  localparam logic [19:0] RA [7] = '{REG_KEY, REG_ADDR_L, REG_ADDR_M, REG_ADDR_H, REG_LEN, REG_PTR_L, REG_PTR_M};
  localparam logic [127:0] KEY1 = 128'h1357_9BDF_2468_ACE0_0F1E_2D3C_4B5A_6978;
  logic clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0, rd_req = 1'b0, lib_call = 1'b0;
  logic irq_active = 1'b0, nvm_done = 1'b0, hold = 1'b0;
  logic [19:0] reg_addr = '0, rd_addr = '0, lib_entry = '0, nvm_addr;
  logic [7:0] reg_wdata = 8'h00, ram_rdata = 8'h00, reg_rdata, data_register_zero, nvm_wdata;
  logic [127:0] lib_key = '0;
  logic [15:0] ram_addr;
  logic rd_ack, rd_deny, nmi, dbl_err, lib_done, busy, ram_re, nvm_we;
  logic [19:0] wa[$];
  logic [7:0] wd[$];
  int miscompares = 0, samples_checked = 0, w0 = 0;

  nspc_ctrl #(.TMO_CYCLES(20)) nspc_ctrl_inst (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .rd_req, .rd_addr, .rd_ack, .rd_deny, .lib_call, .lib_entry, .lib_key, .irq_active,
    .nmi, .dbl_err, .lib_done, .data_register_zero, .busy, .ram_re, .ram_addr, .ram_rdata,
    .nvm_we, .nvm_addr, .nvm_wdata, .nvm_done);

  always #4 clk = ~clk;

  // RAM and macro stand-in; idle RAM data toggles so stale bytes never match
  always @(posedge clk) begin
    ram_rdata <= ram_re ? ram_addr[7:0] ^ 8'h5A : ~ram_rdata;
    nvm_done <= nvm_we & ~hold;
    if (nvm_we) begin
      wa.push_back(nvm_addr);
      wd.push_back(nvm_wdata);
    end
  end

  task automatic final_report;
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  task automatic rr(input logic [19:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    `CHK(reg_rdata, e)
  endtask

  task automatic setp(input logic [19:0] a, input logic [7:0] n, input logic [15:0] p);
    wr(REG_ADDR_L, a[7:0]);
    wr(REG_ADDR_M, a[15:8]);
    wr(REG_ADDR_H, {4'h0, a[19:16]});
    wr(REG_LEN, n);
    wr(REG_PTR_L, p[7:0]);
    wr(REG_PTR_M, p[15:8]);
  endtask

  task automatic go(input logic [19:0] e, input logic [127:0] k = '0);
    @(posedge clk);
    lib_call <= 1'b1;
    lib_entry <= e;
    lib_key <= k;
    w0 = wa.size();
    @(posedge clk);
    lib_call <= 1'b0;
  endtask

  // Result 8'hFF stands for any failure code
  task automatic fin(input logic [7:0] e, input int n);
    int k;
    for (k = 0; k < 2000 && lib_done !== 1'b1; k++) @(negedge clk);
    `CHK(lib_done, 1'b1)
    if (e == 8'hFF) `CHK(data_register_zero == RES_OK, 1'b0)
    else `CHK(data_register_zero, e)
    `CHK(wa.size() - w0, n)
  endtask

  task automatic chkw(input logic [19:0] a, input logic [15:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      `CHK(wa[w0 + i], a + 20'(i))
      `CHK(wd[w0 + i], 8'(p + 16'(i)) ^ 8'h5A)
    end
  endtask

  task automatic rdm(input logic [19:0] a, input int c, input logic dn);
    @(posedge clk);
    rd_req <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_req <= 1'b0;
    for (int i = 1; i < 3; i++) begin
      @(negedge clk);
      `CHK(rd_ack, !dn && i == c)
      `CHK(rd_deny, dn && i == 1)
    end
  endtask

  task automatic t_regs;
    foreach (RA[i]) rr(RA[i], REG_RST);
    foreach (RA[i]) wr(RA[i], 8'hC0 + 8'(i));
    wr(20'h0_3D81, 8'hFF);
    foreach (RA[i]) rr(RA[i], 8'hC0 + 8'(i));
    rr(20'h0_3D81, 8'h00);
  endtask

  task automatic t_nmi;
    go(E_BYTE);
    @(negedge clk);
    `CHK(nmi, 1'b1)
    `CHK(busy, 1'b0)
    wr(REG_KEY, KEY_VAL);
  endtask

  task automatic t_read;
    rdm(CODE0_LO, 1, 1'b0);
    rdm(CODE1_HI, 1, 1'b0);
    rdm(DATA_HI, 2, 1'b0);
    rdm(RSV_LO, 1, 1'b0);
    rdm(20'h1_4000, 1, 1'b1);
  endtask

  task automatic t_write;
    setp(CODE1_LO, MAX_LEN, 16'h0300);
    go(E_WCODE);
    wr(REG_LEN, 8'h00);
    wr(REG_ADDR_L, 8'h55);
    fin(RES_OK, 64);
    chkw(CODE1_LO, 16'h0300, 64);
    setp(DATA_LO, 8'h02, 16'h0010);
    go(E_WDATA);
    fin(RES_OK, 3);
    chkw(DATA_LO, 16'h0010, 3);
    setp(DATA_LO, 8'h40, 16'h0010);
    go(E_WDATA);
    fin(RES_PARAM, 0);
    setp(CODE0_LO, 8'h00, 16'h0000);
    go(E_WCODE);
    fin(RES_PARAM, 0);
    setp(RSV_LO, 8'h01, 16'h0000);
    go(E_WCODE);
    fin(8'hFF, 0);
    setp(DATA_LO + 20'h0_0010, 8'h01, 16'h0020);
    go(E_WSUSP);
    fin(RES_OK, 2);
    chkw(DATA_LO + 20'h0_0010, 16'h0020, 2);
    setp(DATA_LO, 8'h00, 16'h0020);
    hold <= 1'b1;
    go(E_BSUSP);
    fin(RES_TMO, 1);
    hold <= 1'b0;
    go(20'h6_F200);
    fin(RES_ENTRY, 0);
  endtask

  task automatic t_prot;
    for (int i = 0; i < 4; i++) begin
      setp(20'h0_4200 + 20'(i * 256), 8'h00, 16'h0010);
      go(E_PROT);
      fin(i < 3 ? RES_OK : RES_FULL, 0);
    end
    setp(20'h0_420F, 8'h00, 16'h0040);
    go(E_BYTE);
    fin(RES_PROT, 0);
    setp(20'h0_4210, 8'h00, 16'h0040);
    go(E_BYTE);
    fin(RES_OK, 1);
    chkw(20'h0_4210, 16'h0040, 1);
  endtask

  task automatic t_dbl;
    setp(20'h0_4600, 8'h00, 16'h0050);
    irq_active <= 1'b1;
    go(E_WDATA);
    repeat (4) @(negedge clk);
    `CHK({busy, ram_re}, 2'b10)
    go(E_KCHK);
    @(negedge clk);
    `CHK(dbl_err, 1'b1)
    rr(REG_STAT, 8'h98);
    @(posedge clk);
    irq_active <= 1'b0;
    fin(RES_OK, 1);
    chkw(20'h0_4600, 16'h0050, 1);
    rr(REG_RES, RES_OK);
    wr(REG_STAT, 8'h10);
    rr(REG_STAT, 8'h08);
  endtask

  task automatic t_sec;
    go(E_KSET, KEY1);
    fin(RES_OK, 0);
    rdm(CODE0_LO, 1, 1'b1);
    rdm(RSV_HI, 1, 1'b0);
    setp(DATA_LO, 8'h00, 16'h0000);
    go(E_BYTE);
    fin(RES_SEC, 0);
    go(E_KSET, ~KEY1);
    fin(RES_KEY, 0);
    go(E_KCHK, KEY1);
    fin(RES_OK, 0);
    rdm(DATA_LO, 2, 1'b0);
  endtask

  // Whole run is under a thousand cycles; limit leaves wide margin
  initial begin
    #400000;
    miscompares++;
    final_report;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_nmi;
    t_read;
    t_write;
    t_prot;
    t_dbl;
    t_sec;
    final_report;
  end
endmodule
